// ### dsol_pkg.sv
// package: constants, register map and carrier types for the drive status outputs
package dsol_pkg;
   // clock and pulse timing
   localparam int CLK_FREQ_HZ    = 10_000_000;
   localparam int PULSE_TIME_MS  = 100;
   localparam int PULSE_CYCLES   = PULSE_TIME_MS * (CLK_FREQ_HZ / 1000);
   // heatsink margin thresholds in degrees C
   localparam logic [7:0] HS_SET_BELOW_C   = 8'h0A;
   localparam logic [7:0] HS_CLEAR_ABOVE_C = 8'h0F;
   // apb register byte addresses
   localparam logic [7:0] ADDR_SEL    = 8'h00;
   localparam logic [7:0] ADDR_CTRL   = 8'h04;
   localparam logic [7:0] ADDR_OLVL   = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   // field layout
   localparam int SEL_W         = 5;
   localparam int SEL_STRIDE    = 8;
   localparam int CTRL_OL_CUR   = 0;
   localparam int CTRL_LINK_DO  = 1;
   localparam int CTRL_FAN_FIT  = 2;
   localparam int CTRL_W        = 3;
   localparam int OLVL_W        = 16;
   // reset values
   localparam logic [31:0]       SEL_RST  = 32'h0000_0000;
   localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
   localparam logic [OLVL_W-1:0] OLVL_RST = 16'hFFFF;
   // status function codes; FN_STAGE0 and FN_TRIP0 name the low bit of a 3-bit and a 4-bit field
   localparam int FN_OVERLOAD = 0;
   localparam int FN_PANEL    = 1;
   localparam int FN_HALTED   = 2;
   localparam int FN_READY    = 3;
   localparam int FN_BYPASS   = 4;
   localparam int FN_SUPPLY   = 5;
   localparam int FN_OUTSIDE  = 6;
   localparam int FN_MACH2    = 7;
   localparam int FN_AUX      = 8;
   localparam int FN_STAGE_P  = 9;
   localparam int FN_CYCLE_P  = 10;
   localparam int FN_STAGE0   = 11;
   localparam int FN_TRIP0    = 14;
   localparam int FN_FAN      = 18;
   localparam int FN_SELFRST  = 19;
   localparam int FN_LINK_DO  = 20;
   localparam int FN_HEATSINK = 21;
   localparam int FN_COUNT    = 22;

   // inputs from the drive core, all on CLOCK
   typedef struct packed {
      logic [15:0] thermal_acc;
      logic [15:0] out_current;
      logic        keypad_mode;
      logic        stopped;
      logic        dc_braking;
      logic        ready;
      logic        chg_active;
      logic        chg_bypass;
      logic        chg_supply;
      logic        chg_output;
      logic        motor2;
      logic        stage_end;
      logic        cycle_end;
      logic [2:0]  stage_num;
      logic [3:0]  trip_code;
      logic        fan_run;
      logic        autoreset;
      logic [7:0]  hs_margin;
   } dsol_drv_s;
endpackage

// ### dsol_top.sv
// module: selectable transistor status outputs with apb configuration
`timescale 1ns/1ps
`default_nettype none
module dsol_top #(
   parameter int N_TERM    = 4,
   parameter int PULSE_CYC = dsol_pkg::PULSE_CYCLES
) (
   input  wire logic               CLOCK,
   input  wire logic               RST,
   input  wire logic               PSEL,
   input  wire logic               PENABLE,
   input  wire logic               PWRITE,
   input  wire logic [7:0]         PADDR,
   input  wire logic [31:0]        PWDATA,
   output var  logic [31:0]        PRDATA,
   output var  logic               PREADY,
   output var  logic               PSLVERR,
   input  wire dsol_pkg::dsol_drv_s DRV_STATUS,
   output var  logic [N_TERM-1:0]  TERM_OUT
);
   localparam int CNT_W = $clog2(PULSE_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PULSE_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

   logic [31:0]                     sel_ff;
   logic [dsol_pkg::CTRL_W-1:0]     ctrl_ff;
   logic [dsol_pkg::OLVL_W-1:0]     olvl_ff;
   logic [31:0]                     prdata_ff;
   logic                            pready_ff;
   logic                            pslverr_ff;
   logic [dsol_pkg::FN_COUNT-1:0]   status_ff;
   logic [dsol_pkg::FN_COUNT-1:0]   nxt_status;
   logic [N_TERM-1:0]               term_ff;
   logic [N_TERM-1:0]               nxt_term;
   logic [CNT_W-1:0]                stage_cnt_ff;
   logic [CNT_W-1:0]                cycle_cnt_ff;
   logic                            hs_warn_ff;
   logic                            addr_ok;
   logic                            setup_ph;
   logic                            wr_take;
   logic [31:0]                     rd_mux;
   logic                            ol_hit;

   // pulse counter next value; an event reloads even mid-pulse
   function automatic logic [CNT_W-1:0] pulse_next(input logic ev, input logic [CNT_W-1:0] cnt);
      logic [CNT_W-1:0] res;
      res = cnt;
      if (ev) begin
         res = CNT_LOAD;
      end else if (cnt != CNT_ZERO) begin
         res = cnt - CNT_ONE;
      end
      return res;
   endfunction

   // apb slave: no wait states, pready raised by the setup edge
   assign setup_ph = PSEL & ~PENABLE;
   assign wr_take  = PSEL & PENABLE & pready_ff & PWRITE & ~pslverr_ff;

   always_comb begin
      addr_ok = 1'b1;
      rd_mux  = 32'h0000_0000;
      case (PADDR)
         dsol_pkg::ADDR_SEL:    rd_mux = sel_ff;
         dsol_pkg::ADDR_CTRL:   rd_mux[dsol_pkg::CTRL_W-1:0] = ctrl_ff;
         dsol_pkg::ADDR_OLVL:   rd_mux[dsol_pkg::OLVL_W-1:0] = olvl_ff;
         dsol_pkg::ADDR_STATUS: rd_mux[dsol_pkg::FN_COUNT-1:0] = status_ff;
         default:               addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= setup_ph;
         pslverr_ff <= setup_ph & ~addr_ok;
         if (setup_ph) begin
            prdata_ff <= PWRITE ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // software settings: terminal selects, control bits, overload level
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sel_ff  <= dsol_pkg::SEL_RST;
         ctrl_ff <= dsol_pkg::CTRL_RST;
         olvl_ff <= dsol_pkg::OLVL_RST;
      end else if (wr_take) begin
         case (PADDR)
            dsol_pkg::ADDR_SEL:  sel_ff  <= PWDATA;
            dsol_pkg::ADDR_CTRL: ctrl_ff <= PWDATA[dsol_pkg::CTRL_W-1:0];
            dsol_pkg::ADDR_OLVL: olvl_ff <= PWDATA[dsol_pkg::OLVL_W-1:0];
            default: ;
         endcase
      end
   end

   // pulse timers for pattern run events
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         stage_cnt_ff <= CNT_ZERO;
         cycle_cnt_ff <= CNT_ZERO;
      end else begin
         stage_cnt_ff <= pulse_next(DRV_STATUS.stage_end, stage_cnt_ff);
         cycle_cnt_ff <= pulse_next(DRV_STATUS.cycle_end, cycle_cnt_ff);
      end
   end

   // heatsink warning with hysteresis; between thresholds it holds
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         hs_warn_ff <= 1'b0;
      end else if (DRV_STATUS.hs_margin < dsol_pkg::HS_SET_BELOW_C) begin
         hs_warn_ff <= 1'b1;
      end else if (DRV_STATUS.hs_margin > dsol_pkg::HS_CLEAR_ABOVE_C) begin
         hs_warn_ff <= 1'b0;
      end
   end

   // overload source chosen by control bit
   assign ol_hit = ctrl_ff[dsol_pkg::CTRL_OL_CUR] ? (DRV_STATUS.out_current > olvl_ff)
                                                   : (DRV_STATUS.thermal_acc > olvl_ff);

   always_comb begin
      nxt_status = '0;
      nxt_status[dsol_pkg::FN_OVERLOAD] = ol_hit;
      nxt_status[dsol_pkg::FN_PANEL]    = DRV_STATUS.keypad_mode;
      nxt_status[dsol_pkg::FN_HALTED]   = DRV_STATUS.stopped | DRV_STATUS.dc_braking;
      nxt_status[dsol_pkg::FN_READY]    = DRV_STATUS.ready;
      nxt_status[dsol_pkg::FN_BYPASS]   = DRV_STATUS.chg_active & DRV_STATUS.chg_bypass;
      nxt_status[dsol_pkg::FN_SUPPLY]   = DRV_STATUS.chg_active & DRV_STATUS.chg_supply;
      nxt_status[dsol_pkg::FN_OUTSIDE]  = DRV_STATUS.chg_active & DRV_STATUS.chg_output;
      nxt_status[dsol_pkg::FN_AUX]      = DRV_STATUS.chg_active & DRV_STATUS.chg_output;
      nxt_status[dsol_pkg::FN_MACH2]    = DRV_STATUS.motor2;
      nxt_status[dsol_pkg::FN_STAGE_P]  = stage_cnt_ff != CNT_ZERO;
      nxt_status[dsol_pkg::FN_CYCLE_P]  = cycle_cnt_ff != CNT_ZERO;
      nxt_status[dsol_pkg::FN_STAGE0 +: 3] = DRV_STATUS.stage_num;
      nxt_status[dsol_pkg::FN_TRIP0 +: 4]  = DRV_STATUS.trip_code;
      // small ratings have no fan, so the bit stays low unless fitted
      nxt_status[dsol_pkg::FN_FAN]      = DRV_STATUS.fan_run & ctrl_ff[dsol_pkg::CTRL_FAN_FIT];
      nxt_status[dsol_pkg::FN_SELFRST]  = DRV_STATUS.autoreset;
      nxt_status[dsol_pkg::FN_LINK_DO]  = ctrl_ff[dsol_pkg::CTRL_LINK_DO];
      nxt_status[dsol_pkg::FN_HEATSINK] = hs_warn_ff;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         status_ff <= '0;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // terminal mux is registered, so a select or status change never glitches a pin
   always_comb begin
      nxt_term = '0;
      for (int i = 0; i < N_TERM; i++) begin
         if (int'(sel_ff[i*dsol_pkg::SEL_STRIDE +: dsol_pkg::SEL_W]) < dsol_pkg::FN_COUNT) begin
            nxt_term[i] = status_ff[sel_ff[i*dsol_pkg::SEL_STRIDE +: dsol_pkg::SEL_W]];
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         term_ff <= '0;
      end else begin
         term_ff <= nxt_term;
      end
   end

   assign PRDATA   = prdata_ff;
   assign PREADY   = pready_ff;
   assign PSLVERR  = pslverr_ff;
   assign TERM_OUT = term_ff;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   a_overload_thermal: assert property (
      !ctrl_ff[dsol_pkg::CTRL_OL_CUR] && DRV_STATUS.thermal_acc > olvl_ff && !$changed(ctrl_ff)
      |=> status_ff[dsol_pkg::FN_OVERLOAD])
      else $error("overload warning missed");
   a_panel_follow: assert property (
      ##1 status_ff[dsol_pkg::FN_PANEL] == $past(DRV_STATUS.keypad_mode))
      else $error("panel indication wrong");
   a_halted_follow: assert property (
      DRV_STATUS.stopped || DRV_STATUS.dc_braking |=> status_ff[dsol_pkg::FN_HALTED])
      else $error("halted indication missing");
   a_ready_follow: assert property (
      !DRV_STATUS.ready |=> !status_ff[dsol_pkg::FN_READY])
      else $error("ready while not ready");
   a_bypass_idle: assert property (
      !DRV_STATUS.chg_active |=> !status_ff[dsol_pkg::FN_BYPASS])
      else $error("bypass command outside changeover");
   a_aux_match: assert property (
      status_ff[dsol_pkg::FN_AUX] == status_ff[dsol_pkg::FN_OUTSIDE])
      else $error("aux differs from output contactor");
   a_stage_load: assert property (
      DRV_STATUS.stage_end |=> stage_cnt_ff == CNT_LOAD ##1 status_ff[dsol_pkg::FN_STAGE_P])
      else $error("stage pulse not started");
   a_pulse_decay: assert property (
      cycle_cnt_ff != CNT_ZERO && !DRV_STATUS.cycle_end
      |=> cycle_cnt_ff == $past(cycle_cnt_ff) - CNT_ONE)
      else $error("cycle pulse count wrong");
   a_trip_code: assert property (
      ##1 status_ff[dsol_pkg::FN_TRIP0 +: 4] == $past(DRV_STATUS.trip_code))
      else $error("trip code mismatch");
   a_hs_hyst: assert property (
      DRV_STATUS.hs_margin >= dsol_pkg::HS_SET_BELOW_C
      && DRV_STATUS.hs_margin <= dsol_pkg::HS_CLEAR_ABOVE_C |=> $stable(hs_warn_ff))
      else $error("heatsink warning moved inside band");
   a_hs_clear: assert property (
      DRV_STATUS.hs_margin > dsol_pkg::HS_CLEAR_ABOVE_C |=> !hs_warn_ff)
      else $error("heatsink warning not cleared");
   a_term_zero: assert property (
      $stable(sel_ff) && sel_ff[dsol_pkg::SEL_W-1:0] == dsol_pkg::SEL_W'(dsol_pkg::FN_HALTED)
      |=> TERM_OUT[0] == $past(status_ff[dsol_pkg::FN_HALTED]))
      else $error("terminal 0 not following selection");
   a_apb_ready: assert property (
      PSEL && !PENABLE |=> PREADY ##1 !PREADY)
      else $error("apb ready timing wrong");

   c_stage_retrig: cover property (
      stage_cnt_ff != CNT_ZERO && stage_cnt_ff != CNT_LOAD && DRV_STATUS.stage_end);
   c_hs_cycle: cover property (hs_warn_ff ##[1:50] !hs_warn_ff);
   c_apb_write: cover property (wr_take && PADDR == dsol_pkg::ADDR_SEL);
   c_slv_err: cover property (PSLVERR && PREADY);
endmodule
`default_nettype wire

// ### dsol_relay_model.sv
// model of the relays wired to the transistor terminals
`timescale 1ns/1ps
`default_nettype none
module dsol_relay_model #(
   parameter int N = 4
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [N-1:0] coil,
   output var  logic [N-1:0] contact
);
   // one clock of pickup stands in for armature travel
   always_ff @(posedge clock) begin
      if (rst) begin
         contact <= '0;
      end else begin
         contact <= coil;
      end
   end
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the drive status outputs
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int PC = 20;
   logic                clock   = 1'b0;
   logic                rst     = 1'b1;
   logic                psel    = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite  = 1'b0;
   logic [7:0]          paddr   = 8'h00;
   logic [31:0]         pwdata  = 32'h0;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   dsol_pkg::dsol_drv_s drv     = '0;
   logic [3:0]          term;
   logic [3:0]          contact;
   logic [2:0]          ctrl    = 3'h0;
   logic [15:0]         olvl    = 16'hFFFF;
   logic                hs      = 1'b0;
   int                  num_errors = 0;
   int                  n_tests    = 0;

   always #50 clock = ~clock;

   dsol_top #(.N_TERM(4), .PULSE_CYC(PC)) dut (
      .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .DRV_STATUS(drv), .TERM_OUT(term));
   dsol_relay_model #(.N(4)) load (.clock(clock), .rst(rst), .coil(term), .contact(contact));

   task finish_test;
      if (num_errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      // ready is taken at the rising edge that ends the access, before its own update
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         num_errors++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
      chk({31'h0, e}, {31'h0, exp_err});
   endtask

   function automatic logic [21:0] exp_st(dsol_pkg::dsol_drv_s d);
      logic [21:0] s;
      s = '0;
      s[0] = ctrl[0] ? (d.out_current > olvl) : (d.thermal_acc > olvl);
      s[1] = d.keypad_mode;
      s[2] = d.stopped | d.dc_braking;
      s[3] = d.ready;
      s[4] = d.chg_active & d.chg_bypass;
      s[5] = d.chg_active & d.chg_supply;
      s[6] = d.chg_active & d.chg_output;
      s[7] = d.motor2;
      s[8] = s[6];
      s[13:11] = d.stage_num;
      s[17:14] = d.trip_code;
      s[18] = d.fan_run & ctrl[2];
      s[19] = d.autoreset;
      s[20] = ctrl[1];
      s[21] = hs;
      return s;
   endfunction

   // f packs panel, stopped, dc brake, ready, changeover, bypass, supply, output, motor2
   task apply(input logic [15:0] th, input logic [15:0] cu, input logic [8:0] f,
              input logic [2:0] sn, input logic [3:0] tc, input logic fan,
              input logic ar, input logic [7:0] m);
      logic [21:0] st;
      logic [31:0] sel;
      logic [31:0] r;
      logic        e;
      logic [3:0]  ex;
      int          c;
      @(posedge clock);
      drv <= {th, cu, f, 2'b00, sn, tc, fan, ar, m};
      repeat (4) @(posedge clock);
      if (drv.hs_margin < dsol_pkg::HS_SET_BELOW_C) hs = 1'b1;
      if (drv.hs_margin > dsol_pkg::HS_CLEAR_ABOVE_C) hs = 1'b0;
      st = exp_st(drv);
      apb(1'b0, dsol_pkg::ADDR_STATUS, 32'h0, r, e);
      chk(r & 32'h0000_001F, {27'h0, st[4:0]});
      chk((r >> 5) & 32'h0000_000F, {28'h0, st[8:5]});
      chk(r >> 11, {21'h0, st[21:11]});
      for (int g = 0; g < 6; g++) begin
         sel = 32'h0;
         for (int i = 0; i < 4; i++) begin
            c = 4 * g + i;
            sel[8*i +: 8] = {3'h0, c[4:0]};
            ex[i] = (c < dsol_pkg::FN_COUNT) ? st[c] : 1'b0;
         end
         wr(dsol_pkg::ADDR_SEL, sel);
         repeat (5) @(posedge clock);
         chk({28'h0, contact}, {28'h0, ex});
      end
   endtask

   initial begin
      logic [31:0] n0;
      logic [31:0] n1;
      logic [31:0] rise;
      logic        prev;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rdc(dsol_pkg::ADDR_SEL, dsol_pkg::SEL_RST, 1'b0);
      rdc(dsol_pkg::ADDR_CTRL, {29'h0, dsol_pkg::CTRL_RST}, 1'b0);
      rdc(dsol_pkg::ADDR_OLVL, {16'h0, dsol_pkg::OLVL_RST}, 1'b0);
      wr(8'h10, 32'h0000_00FF);
      rdc(8'h10, 32'h0, 1'b1);
      rdc(dsol_pkg::ADDR_SEL, 32'h0, 1'b0);
      wr(dsol_pkg::ADDR_SEL, 32'h1F15_0A03);
      rdc(dsol_pkg::ADDR_SEL, 32'h1F15_0A03, 1'b0);
      olvl = 16'h1234;
      wr(dsol_pkg::ADDR_OLVL, {16'h0, olvl});
      rdc(dsol_pkg::ADDR_OLVL, {16'h0, olvl}, 1'b0);
      // levels one above and equal to the alarm level, margins across both thresholds
      apply(16'h1235, 16'h0000, 9'b101111010, 3'h5, 4'hA, 1'b1, 1'b1, 8'h14);
      apply(16'h1234, 16'hFFFF, 9'b010010101, 3'h2, 4'h5, 1'b1, 1'b0, 8'h09);
      ctrl = 3'h7;
      wr(dsol_pkg::ADDR_CTRL, {29'h0, ctrl});
      rdc(dsol_pkg::ADDR_CTRL, {29'h0, ctrl}, 1'b0);
      apply(16'hFFFF, 16'h1235, 9'b000001111, 3'h7, 4'hF, 1'b1, 1'b1, 8'h0F);
      apply(16'h0000, 16'h1234, 9'b111111111, 3'h0, 4'h8, 1'b0, 1'b0, 8'h10);
      ctrl = 3'h0;
      wr(dsol_pkg::ADDR_CTRL, {29'h0, ctrl});
      apply(16'h0000, 16'h0000, 9'b000000000, 3'h0, 4'h0, 1'b1, 1'b0, 8'h0A);
      wr(dsol_pkg::ADDR_SEL, {19'h0, 5'(dsol_pkg::FN_CYCLE_P), 3'h0, 5'(dsol_pkg::FN_STAGE_P)});
      repeat (5) @(posedge clock);
      n0 = 0;
      n1 = 0;
      rise = 0;
      prev = 1'b0;
      // a second stage end ten cycles in restarts the stage pulse
      for (int k = 0; k < 80; k++) begin
         @(posedge clock);
         drv.stage_end <= (k == 0 || k == 10);
         drv.cycle_end <= (k == 0);
         @(negedge clock);
         n0 += (contact[0] === 1'b1);
         n1 += (contact[1] === 1'b1);
         rise += (contact[0] === 1'b1 && prev === 1'b0);
         prev = contact[0];
      end
      chk(n0, PC + 10);
      chk(n1, PC);
      chk(rise, 32'h1);
      finish_test;
   end

   // the sequence needs about 410 cycles; nearly fifty times that means a hang
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      finish_test;
   end
endmodule
`default_nettype wire
